//--- sbm_pkg.sv
// Constants and types for the stack and block-move address generator
package sbm_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 8;
	localparam int IDX_W = 32;
	localparam logic [7:0] BANK_ZERO = 8'h00;
	localparam logic [7:0] TOP_ZERO = 8'h00;
	localparam logic [15:0] UPPER_ZERO = 16'h0000;
	localparam logic [15:0] PTR_STEP = 16'h0001;
	localparam logic [31:0] IDX_STEP32 = 32'h0000_0001;
	localparam logic [15:0] IDX_STEP16 = 16'h0001;
	localparam logic [15:0] CNT_ZERO16 = 16'h0000;
	localparam logic [31:0] CNT_ZERO32 = 32'h0000_0000;

	typedef enum logic [2:0] {
		SBM_MODE_STACK = 3'h0,
		SBM_MODE_VECTOR = 3'h1,
		SBM_MODE_SREL = 3'h2,
		SBM_MODE_SRII = 3'h3,
		SBM_MODE_MV_ASC = 3'h4,
		SBM_MODE_MV_DESC = 3'h5
	} sbm_mode_t;

	typedef enum logic [2:0] {
		SBM_ST_IDLE = 3'h0,
		SBM_ST_PTR_LO = 3'h1,
		SBM_ST_PTR_HI = 3'h2,
		SBM_ST_MV_RD = 3'h3,
		SBM_ST_MV_WR = 3'h4
	} sbm_state_t;

	typedef struct packed {
		logic valid;
		sbm_mode_t mode;
		logic native;
		logic [15:0] sp;
		logic [15:0] vec_addr;
		logic [7:0] byte2;
		logic [7:0] byte3;
		logic [31:0] x;
		logic [31:0] y;
		logic [31:0] acc;
		logic [7:0] data_bank_reg;
	} sbm_req_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [31:0] addr;
		logic [7:0] wdata;
	} sbm_mem_t;

	typedef struct packed {
		logic done;
		logic restart;
		logic [31:0] ea;
		logic [31:0] x;
		logic [31:0] y;
		logic [31:0] acc;
		logic [7:0] data_bank_reg;
	} sbm_res_t;

	typedef struct packed {
		sbm_state_t state;
		sbm_mode_t mode;
		logic native;
		logic [15:0] ptr;
		logic [7:0] ptr_lo;
		logic [7:0] src_bank;
		sbm_mem_t mem;
		sbm_res_t res;
	} sbm_st_t;

	localparam sbm_st_t SBM_ST_RESET = '0;
endpackage

//--- sbm_addr_gen.sv
// Stack and block-move effective address generator
`timescale 1ns/10ps
`default_nettype none
module sbm_addr_gen
	import sbm_pkg::*;
#(
	parameter int ADDR_WIDTH = ADDR_W
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire sbm_req_t req,
	output logic req_ready,
	output sbm_mem_t mem,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_rdy,
	output sbm_res_t res
);

	generate
		if (ADDR_WIDTH != 32) begin : g_bad_width
			$error("sbm_addr_gen supports only a 32-bit address");
		end
	endgenerate

	sbm_st_t q, d;
	logic take;
	logic [23:0] base24;
	logic [31:0] src_addr;
	logic [31:0] dst_addr;
	logic remain;

	assign req_ready = (q.state == SBM_ST_IDLE);
	assign take = req.valid && req_ready;
	assign mem = q.mem;
	assign res = q.res;

	always_comb begin
		d = q;
		d.res.done = 1'b0;
		d.res.restart = 1'b0;
		base24 = {q.res.data_bank_reg, mem_rdata, q.ptr_lo};
		src_addr = q.native ? q.res.x : {TOP_ZERO, q.src_bank, q.res.x[15:0]};
		dst_addr = q.native ? q.res.y : {TOP_ZERO, q.res.data_bank_reg, q.res.y[15:0]};
		remain = q.native ? (q.res.acc != CNT_ZERO32) : (q.res.acc[15:0] != CNT_ZERO16);
		case (q.state)
			SBM_ST_IDLE: begin
				if (take) begin
					d.mode = req.mode;
					d.native = req.native;
					d.res.x = req.x;
					d.res.y = req.y;
					d.res.acc = req.acc;
					d.res.data_bank_reg = req.data_bank_reg;
					case (req.mode)
						SBM_MODE_STACK: begin
							d.res.ea = {UPPER_ZERO, req.sp};
							d.res.done = 1'b1;
						end
						SBM_MODE_VECTOR: begin
							d.res.ea = {UPPER_ZERO, req.vec_addr};
							d.res.done = 1'b1;
						end
						SBM_MODE_SREL: begin
							d.res.ea = {UPPER_ZERO, req.sp + {8'h00, req.byte2}};
							d.res.done = 1'b1;
						end
						SBM_MODE_SRII: begin
							d.ptr = req.sp + {8'h00, req.byte2};
							d.mem.rd = 1'b1;
							d.mem.addr = {UPPER_ZERO, req.sp + {8'h00, req.byte2}};
							d.state = SBM_ST_PTR_LO;
						end
						SBM_MODE_MV_ASC, SBM_MODE_MV_DESC: begin
							d.res.data_bank_reg = req.byte2;
							d.src_bank = req.byte3;
							d.mem.rd = 1'b1;
							d.mem.addr = req.native ? req.x : {TOP_ZERO, req.byte3, req.x[15:0]};
							d.state = SBM_ST_MV_RD;
						end
						default: begin
							d.res.done = 1'b1;
						end
					endcase
				end
			end
			SBM_ST_PTR_LO: begin
				if (mem_rdy) begin
					d.ptr_lo = mem_rdata;
					d.mem.addr = {UPPER_ZERO, q.ptr + PTR_STEP};
					d.state = SBM_ST_PTR_HI;
				end
			end
			SBM_ST_PTR_HI: begin
				if (mem_rdy) begin
					d.mem.rd = 1'b0;
					if (q.native) begin
						d.res.ea = {TOP_ZERO, base24} + q.res.y;
					end else begin
						d.res.ea = {TOP_ZERO, base24 + {8'h00, q.res.y[15:0]}};
					end
					d.res.done = 1'b1;
					d.state = SBM_ST_IDLE;
				end
			end
			SBM_ST_MV_RD: begin
				if (mem_rdy) begin
					d.mem.rd = 1'b0;
					d.mem.wr = 1'b1;
					d.mem.wdata = mem_rdata;
					d.mem.addr = dst_addr;
					d.res.ea = src_addr;
					d.state = SBM_ST_MV_WR;
				end
			end
			SBM_ST_MV_WR: begin
				if (mem_rdy) begin
					d.mem.wr = 1'b0;
					if (q.native) begin
						if (q.mode == SBM_MODE_MV_ASC) begin
							d.res.x = q.res.x + IDX_STEP32;
							d.res.y = q.res.y + IDX_STEP32;
						end else begin
							d.res.x = q.res.x - IDX_STEP32;
							d.res.y = q.res.y - IDX_STEP32;
						end
						d.res.acc = q.res.acc - IDX_STEP32;
					end else begin
						if (q.mode == SBM_MODE_MV_ASC) begin
							d.res.x[15:0] = q.res.x[15:0] + IDX_STEP16;
							d.res.y[15:0] = q.res.y[15:0] + IDX_STEP16;
						end else begin
							d.res.x[15:0] = q.res.x[15:0] - IDX_STEP16;
							d.res.y[15:0] = q.res.y[15:0] - IDX_STEP16;
						end
						d.res.acc[15:0] = q.res.acc[15:0] - IDX_STEP16;
					end
					d.res.restart = remain;
					d.res.done = 1'b1;
					d.state = SBM_ST_IDLE;
				end
			end
			default: begin
				d = SBM_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			q <= SBM_ST_RESET;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_take(sbm_mode_t m);
		take && req.mode == m;
	endsequence

	sequence s_wr_end;
		q.state == SBM_ST_MV_WR && mem_rdy;
	endsequence

	a_stack_bank_zero: assert property (
		s_take(SBM_MODE_STACK) |=> res.done && res.ea == {16'h0000, $past(req.sp)})
		else $error("stack address not in bank zero");

	a_vector_bank_zero: assert property (
		s_take(SBM_MODE_VECTOR) |=> res.done && res.ea[31:16] == 16'h0000 && res.ea[15:0] == $past(req.vec_addr))
		else $error("vector fetch not in bank zero");

	a_srel_low_sum: assert property (
		s_take(SBM_MODE_SREL) |=> res.ea[15:0] == 16'($past(req.sp) + {8'h00, $past(req.byte2)}))
		else $error("stack relative sum wrong");

	a_srel_upper_zero: assert property (
		s_take(SBM_MODE_SREL) |=> res.done && res.ea[31:16] == 16'h0000)
		else $error("stack relative upper bits not zero");

	a_srel_offset_unsigned: assert property (
		s_take(SBM_MODE_SREL) && req.byte2[7] |=> 16'(res.ea[15:0] - $past(req.sp)) == {8'h00, $past(req.byte2)})
		else $error("stack relative offset sign extended");

	a_ptr_read_bank0: assert property (
		s_take(SBM_MODE_SRII) |=> mem.rd && mem.addr == {16'h0000, 16'($past(req.sp) + {8'h00, $past(req.byte2)})}
			##1 (mem.addr[31:16] == 16'h0000)[*1])
		else $error("pointer read outside bank zero");

	a_srii_bank_dbr: assert property (
		q.state == SBM_ST_PTR_HI && mem_rdy && !q.native && q.res.y[15:0] == 16'h0000
		|=> res.ea[23:16] == q.res.data_bank_reg && res.done)
		else $error("base bank not from data bank register");

	a_srii_emul_ea: assert property (
		q.state == SBM_ST_PTR_HI && mem_rdy && !q.native
		|=> res.ea == {8'h00, 24'({$past(q.res.data_bank_reg), $past(mem_rdata), $past(q.ptr_lo)}
			+ {8'h00, $past(q.res.y[15:0])})})
		else $error("indirect indexed address wrong");

	a_srii_native_ea: assert property (
		q.state == SBM_ST_PTR_HI && mem_rdy && q.native
		|=> res.ea == {8'h00, $past(q.res.data_bank_reg), $past(mem_rdata), $past(q.ptr_lo)} + $past(q.res.y))
		else $error("native indirect indexed address wrong");

	a_mv_dst_addr: assert property (
		q.state == SBM_ST_MV_WR && !q.native |-> mem.wr && mem.addr == {8'h00, q.res.data_bank_reg, q.res.y[15:0]})
		else $error("block move destination address wrong");

	a_mv_src_addr: assert property (
		q.state == SBM_ST_MV_RD && !q.native |-> mem.rd && mem.addr == {8'h00, q.src_bank, q.res.x[15:0]})
		else $error("block move source address wrong");

	a_mv_count_last: assert property (
		s_wr_end and (q.res.acc == 32'h0000_0000) |=> res.done && !res.restart)
		else $error("zero count did not end after one byte");

	a_mv_bank_load: assert property (
		(s_take(SBM_MODE_MV_ASC) or s_take(SBM_MODE_MV_DESC)) |=> res.data_bank_reg == $past(req.byte2))
		else $error("data bank register not loaded");

	a_mv_native_full: assert property (
		q.native && q.state == SBM_ST_MV_RD |-> mem.addr == q.res.x ##1 (q.state != SBM_ST_MV_WR || mem.addr == q.res.y))
		else $error("native block move address not full index");

	a_mv_index_step: assert property (
		s_wr_end and (q.native && q.mode == SBM_MODE_MV_DESC)
		|=> res.x == $past(q.res.x) - 32'h1 && res.y == $past(q.res.y) - 32'h1 && res.acc == $past(q.res.acc) - 32'h1)
		else $error("descending step wrong");

	a_mv_restart: assert property (
		s_wr_end and (q.native && q.res.acc != 32'h0000_0000) |=> res.restart && res.done ##1 !res.restart)
		else $error("restart missing while bytes remain");

endmodule
`default_nettype wire

//--- sbm_mem_model.sv
// Memory model answering reads and writes after a chosen delay
`timescale 1ns/10ps
`default_nettype none
module sbm_mem_model
	import sbm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire sbm_mem_t mem,
	input wire logic [1:0] dly,
	output logic [7:0] mem_rdata,
	output logic mem_rdy
);
	logic [1:0] cnt_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mem_rdy <= 1'b0;
			cnt_q <= 2'h0;
			mem_rdata <= 8'h00;
		end else if (!mem_rdy && (mem.rd || mem.wr) && cnt_q >= dly) begin
			mem_rdy <= 1'b1;
			mem_rdata <= mem.rd ? (mem.addr[7:0] ^ mem.addr[15:8] ^ mem.addr[23:16] ^ 8'h5a) : ~mem_rdata;
		end else begin
			// Data toggles outside the answer cycle
			mem_rdy <= 1'b0;
			cnt_q <= ((mem.rd || mem.wr) && !mem_rdy) ? cnt_q + 2'h1 : 2'h0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule
`default_nettype wire

//--- sbm_addr_gen_bench.sv
// Self-checking bench for the stack and block-move address generator
`timescale 1ns/10ps
`default_nettype none
module sbm_addr_gen_bench
	import sbm_pkg::*;
;
	logic sys_clk, nrst, req_ready, mem_rdy;
	logic [7:0] mem_rdata;
	logic [1:0] dly;
	sbm_req_t req;
	sbm_mem_t mem;
	sbm_res_t res;
	int n_errors, checks_done;
	logic [31:0] ra[$], wa[$], wd[$];
	sbm_addr_gen dut_u (.sys_clk(sys_clk), .nrst(nrst), .req(req), .req_ready(req_ready), .mem(mem),
		.mem_rdata(mem_rdata), .mem_rdy(mem_rdy), .res(res));
	sbm_mem_model mem_u (.sys_clk(sys_clk), .nrst(nrst), .mem(mem), .dly(dly), .mem_rdata(mem_rdata),
		.mem_rdy(mem_rdy));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (mem_rdy && mem.rd) ra.push_back(mem.addr);
		if (mem_rdy && mem.wr) begin
			wa.push_back(mem.addr);
			wd.push_back({24'h0, mem.wdata});
		end
	end
	function automatic logic [7:0] fdat(logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic run();
		int k;
		ra.delete();
		wa.delete();
		wd.delete();
		dly = 2'($urandom % 4);
		req.valid = 1'b1;
		@(negedge sys_clk);
		req.valid = 1'b0;
		for (k = 0; k < 50 && res.done !== 1'b1; k++) @(negedge sys_clk);
		chk("done", 32'h1, {31'h0, res.done});
		chk("ready", 32'h1, {31'h0, req_ready});
	endtask
	initial begin
		#(25 * 20000);
		n_errors++;
		give_verdict();
	end
	initial begin
		sbm_req_t q;
		logic [31:0] e, s, d, st;
		logic [15:0] p;
		logic em;
		req = '0;
		dly = 2'h0;
		nrst = 1'b0;
		n_errors = 0;
		checks_done = 0;
		void'($urandom(32'h748d));
		repeat (16) @(negedge sys_clk);
		nrst = 1'b1;
		@(negedge sys_clk);
		for (int i = 0; i < 240; i++) begin
			req.mode = sbm_mode_t'(i % 8);
			req.native = i[3];
			req.sp = (i < 12) ? 16'hffff : 16'($urandom);
			req.vec_addr = 16'($urandom);
			req.byte2 = (i < 12) ? 8'hff : 8'($urandom);
			req.byte3 = 8'($urandom);
			req.x = $urandom;
			req.y = (i < 12) ? 32'h0 : $urandom;
			req.acc = (i < 24) ? 32'h0 : ($urandom & 32'h0001_0003);
			req.data_bank_reg = 8'($urandom);
			q = req;
			run();
			p = q.sp + 16'(q.byte2);
			case (q.mode)
				SBM_MODE_STACK: chk("stack ea", {16'h0, q.sp}, res.ea);
				SBM_MODE_VECTOR: chk("vector ea", {16'h0, q.vec_addr}, res.ea);
				SBM_MODE_SREL: chk("srel ea", {16'h0, p}, res.ea);
				SBM_MODE_SRII: begin
					chk("ptr lo", {16'h0, p}, ra[0]);
					chk("ptr hi", {16'h0, p + 16'h1}, ra[1]);
					e = {8'h0, q.data_bank_reg, fdat({16'h0, p + 16'h1}), fdat({16'h0, p})};
					e = q.native ? e + q.y : {8'h0, 24'(e[23:0] + {8'h0, q.y[15:0]})};
					chk("srii ea", e, res.ea);
				end
				SBM_MODE_MV_ASC, SBM_MODE_MV_DESC: begin
					s = q.native ? q.x : {8'h0, q.byte3, q.x[15:0]};
					d = q.native ? q.y : {8'h0, q.byte2, q.y[15:0]};
					chk("src", s, ra[0]);
					chk("dst", d, wa[0]);
					chk("wdata", {24'h0, fdat(s)}, wd[0]);
					chk("bytes", 32'h1, 32'(wa.size()));
					chk("bank", {24'h0, q.byte2}, {24'h0, res.data_bank_reg});
					st = (q.mode == SBM_MODE_MV_ASC) ? 32'h1 : 32'hffff_ffff;
					chk("x", q.native ? q.x + st : {q.x[31:16], q.x[15:0] + st[15:0]}, res.x);
					chk("y", q.native ? q.y + st : {q.y[31:16], q.y[15:0] + st[15:0]}, res.y);
					em = q.native ? (q.acc != 32'h0) : (q.acc[15:0] != 16'h0);
					chk("restart", {31'h0, em}, {31'h0, res.restart});
					chk("acc", q.native ? q.acc - 32'h1 : {q.acc[31:16], q.acc[15:0] - 16'h1}, res.acc);
				end
				default: begin
					chk("idle bus", 32'h0, 32'(ra.size() + wa.size()));
					chk("no restart", 32'h0, {31'h0, res.restart});
				end
			endcase
		end
		give_verdict();
	end
endmodule
`default_nettype wire
